/* File: mcs_master_clk.sv */
// Master clock selector: APB control, reference monitor and clock fan-out.
//
// Overview of operation
// - Synthesize one 1.544 or 2.048 MHz clock.
// - Feed master clock to every channel's shaper, recovery.
// - Separate E1-rate and T1-rate reference inputs.
// - All channels share one master rate.
// - Codes 010-111 pick 8-256 kHz on E1 input.
// - Code 000 uses E1 input, 001 T1.
// - Rate select 0 gives 2048, 1 gives 1544.
// - Host mode takes selects from control register.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "mcs_params.svh"
module mcs_master_clk
	import mcs_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              host_mode,
	input  wire logic [2:0]        ref_freq_select,
	input  wire logic              output_rate_select,
	input  wire logic              e1_rate_ref_clock_in,
	input  wire logic              t1_rate_ref_clock_in,
	output logic                   master_clk,
	output logic      [NUM_CH-1:0] tx_shaper_clk,
	output logic      [NUM_CH-1:0] rx_recovery_clk,
	output logic                   master_rate_t1,
	output logic                   ref_ok
);

	localparam int CNT_W = 13; // Holds twice the slowest reference period plus slack.
	localparam logic [31:0] E1_INCR = 32'((64'(`MCS_E1_KHZ) << 32) / `MCS_CLK_KHZ);
	localparam logic [31:0] T1_INCR = 32'((64'(`MCS_T1_KHZ) << 32) / `MCS_CLK_KHZ);

	// Refuse a channel count the fan-out cannot serve.
	if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_ch
		$error("mcs_master_clk: NUM_CH must be 1 to 32.");
	end

	// Reference rate in kHz for a select code.
	function automatic logic [11:0] ref_khz(input logic [2:0] code);
		logic [11:0] k;
		k = 12'(`MCS_E1_KHZ);
		if (code == `MCS_SEL_T1_FULL) k = 12'(`MCS_T1_KHZ);
		else if (code == 3'h2) k = 12'(`MCS_REF8_KHZ);
		else if (code == 3'h3) k = 12'(`MCS_REF16_KHZ);
		else if (code == 3'h4) k = 12'(`MCS_REF56_KHZ);
		else if (code == 3'h5) k = 12'(`MCS_REF64_KHZ);
		else if (code == 3'h6) k = 12'(`MCS_REF128_KHZ);
		else if (code == 3'h7) k = 12'(`MCS_REF256_KHZ);
		return k;
	endfunction

	// Only the full T1 code watches the T1-rate input; all others use the E1-rate one.
	function automatic mcs_src_t src_of(input logic [2:0] code);
		return (code == `MCS_SEL_T1_FULL) ? MCS_SRC_T1 : MCS_SRC_E1;
	endfunction

	logic [3:0]       ctrl_reg;      // Host-programmed selects.
	mcs_sel_t         sel_reg;       // Selection in force.
	mcs_sel_t         sel_next;      // Selection from pins or register.
	logic [31:0]      prdata_reg;    // Read data captured in the setup cycle.
	logic             ref_prev_reg;  // Previous sample of the watched reference.
	logic [CNT_W-1:0] cnt_reg;       // Cycles since the last reference edge.
	logic             ok_reg;        // Reference seen at the expected rate.
	mcs_mon_t         mon_reg;       // Reference monitor state.
	mcs_src_t         src;           // Watched reference input.
	logic             ref_now;       // Current sample of the watched reference.
	logic             ref_rise;      // Rising edge of the watched reference.
	logic [CNT_W-1:0] exp_cyc;       // Expected reference period in bus cycles.
	logic [CNT_W-1:0] tol_cyc;       // Allowed period error.
	logic [CNT_W-1:0] tmo_cyc;       // Cycles without an edge that mean loss.
	logic [31:0]      incr;          // Frequency word for the synthesizer.
	logic             acc_w;         // Access phase of a write.
	logic             ctrl_hit;      // Address decodes to the control register.
	logic             stat_hit;      // Address decodes to the status register.
	logic [31:0]      incr_prev_reg; // Frequency word of the previous cycle.
	logic [2:0]       hi_cnt_reg;    // Edges at which the master clock was high, saturating.
	logic             hi_chg_reg;    // The frequency word moved during this high phase.

	// Address decode shared by reads and writes.
	always_comb begin
		ctrl_hit = 1'b0;
		stat_hit = 1'b0;
		if (paddr == `MCS_CTRL_OFF) begin
			ctrl_hit = 1'b1;
		end else if (paddr == `MCS_STAT_OFF) begin
			stat_hit = 1'b1;
		end
	end

	// The slave never waits; unmapped addresses answer with an error.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~ctrl_hit & ~stat_hit;
	assign acc_w   = psel & penable & pwrite;
	assign prdata  = prdata_reg;

	// Control register write; the status register is read only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `MCS_CTRL_RST;
		end else if (acc_w && ctrl_hit) begin
			ctrl_reg <= pwdata[3:0];
		end
	end

	// Read data is captured at setup so it leaves a flop in the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= 32'h0;
			if (ctrl_hit) begin
				prdata_reg[3:0] <= ctrl_reg;
			end else if (stat_hit) begin
				prdata_reg[`MCS_STAT_OK_BIT]                    <= ok_reg;
				prdata_reg[`MCS_STAT_RATE_BIT]                  <= sel_reg.rate_t1;
				prdata_reg[`MCS_STAT_SEL_LSB+2:`MCS_STAT_SEL_LSB] <= sel_reg.ref_sel;
				prdata_reg[`MCS_STAT_SRC_BIT]                   <= (src == MCS_SRC_T1);
				prdata_reg[`MCS_STAT_HOST_BIT]                  <= host_mode;
			end
		end
	end

	// Host mode takes the selects from the register, otherwise from the pins.
	always_comb begin
		if (host_mode) begin
			sel_next.ref_sel = ctrl_reg[`MCS_CTRL_SEL_LSB+2:`MCS_CTRL_SEL_LSB];
			sel_next.rate_t1 = ctrl_reg[`MCS_CTRL_RATE_BIT];
		end else begin
			sel_next.ref_sel = ref_freq_select;
			sel_next.rate_t1 = output_rate_select;
		end
	end

	// The selection is registered once for the whole device.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= '0;
		end else begin
			sel_reg <= sel_next;
		end
	end

	// Two reference inputs; the code decides which one is watched.
	assign src     = src_of(sel_reg.ref_sel);
	assign ref_now = (src == MCS_SRC_T1) ? t1_rate_ref_clock_in : e1_rate_ref_clock_in;
	assign ref_rise = ref_now & ~ref_prev_reg;

	// Period window for the selected reference rate.
	assign exp_cyc = CNT_W'(`MCS_CLK_KHZ / ref_khz(sel_reg.ref_sel));
	assign tol_cyc = CNT_W'((exp_cyc >> 3) + 1);
	assign tmo_cyc = CNT_W'((exp_cyc << 1) + 2);

	// Edge history of the watched reference.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_prev_reg <= 1'b0;
		end else begin
			ref_prev_reg <= ref_now;
		end
	end

	// Monitor: measure each reference period and flag loss on a timeout.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_reg <= MCS_MON_WAIT;
			cnt_reg <= '0;
			ok_reg  <= 1'b0;
		end else if (sel_reg != sel_next) begin
			// A new selection restarts the measurement.
			mon_reg <= MCS_MON_WAIT;
			cnt_reg <= '0;
			ok_reg  <= 1'b0;
		end else begin
			case (mon_reg)
				MCS_MON_WAIT: begin
					// Wait for the first edge to start a period.
					if (ref_rise) begin
						mon_reg <= MCS_MON_RUN;
						cnt_reg <= CNT_W'(1);
					end
				end
				MCS_MON_RUN: begin
					if (ref_rise) begin
						// Period in range marks the reference good.
						ok_reg  <= (cnt_reg + tol_cyc >= exp_cyc) &&
							(cnt_reg <= exp_cyc + tol_cyc);
						cnt_reg <= CNT_W'(1);
					end else if (cnt_reg >= tmo_cyc) begin
						// No edge for too long: the reference is lost.
						ok_reg  <= 1'b0;
						mon_reg <= MCS_MON_WAIT;
						cnt_reg <= '0;
					end else begin
						cnt_reg <= cnt_reg + CNT_W'(1);
					end
				end
				default: begin
					mon_reg <= MCS_MON_WAIT;
				end
			endcase
		end
	end

	assign ref_ok         = ok_reg;
	assign master_rate_t1 = sel_reg.rate_t1;

	// The rate select alone picks the output frequency for every code.
	assign incr = sel_reg.rate_t1 ? T1_INCR : E1_INCR;

	// One synthesizer makes the single master clock.
	mcs_nco #(
		.ACC_W (32)
	) mcs_nco_inst (
		.pclk    (pclk),
		.presetn (presetn),
		.incr    (incr),
		.clk_out (master_clk)
	);

	// Every channel's shaper and recovery logic gets the same clock.
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_fan
		assign tx_shaper_clk[ch]   = master_clk;
		assign rx_recovery_clk[ch] = master_clk;
	end

	// Measures each high phase of the master clock for the high-time check.
	// A rate change inside a phase stretches or cuts it, so such phases are marked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			incr_prev_reg <= 32'h0;
			hi_cnt_reg    <= 3'h0;
			hi_chg_reg    <= 1'b0;
		end else begin
			incr_prev_reg <= incr;
			if (!master_clk) begin
				// Low: the next high phase starts from zero.
				hi_cnt_reg <= 3'h0;
				hi_chg_reg <= 1'b0;
			end else begin
				// High: count the edge and note any change of the word.
				if (hi_cnt_reg != 3'h7) begin
					hi_cnt_reg <= hi_cnt_reg + 3'h1;
				end
				hi_chg_reg <= hi_chg_reg | (incr != incr_prev_reg);
			end
		end
	end

	// Checks on the selection, the synthesizer, the fan-out, the monitor and the register port.
	host_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_mode && $stable(ctrl_reg) |=> sel_reg.ref_sel == $past(ctrl_reg[2:0]))
		else $error("Host mode selection does not follow the control register.");
	pin_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		!host_mode |=> sel_reg == {$past(ref_freq_select), $past(output_rate_select)})
		else $error("Hardware mode selection does not follow the pins.");
	rate_word_a: assert property (@(posedge pclk) disable iff (!presetn)
		sel_reg.rate_t1 |=> $past(incr) == T1_INCR || $past(sel_reg.rate_t1) == 1'b0)
		else $error("Rate select 1 did not give the T1 frequency word.");
	e1_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		sel_reg.ref_sel != `MCS_SEL_T1_FULL |-> ref_now == e1_rate_ref_clock_in)
		else $error("E1-rate input not watched for this code.");
	t1_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		sel_reg.ref_sel == `MCS_SEL_T1_FULL |-> ref_now == t1_rate_ref_clock_in)
		else $error("T1-rate input not watched for code 001.");
	clk_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(master_clk) && !hi_chg_reg |-> hi_cnt_reg >= 3'h2 && hi_cnt_reg <= 3'h4)
		else $error("Master clock high time out of range.");
	fanout_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(master_clk) |-> &tx_shaper_clk && &rx_recovery_clk)
		else $error("A channel did not receive the master clock.");
	loss_a: assert property (@(posedge pclk) disable iff (!presetn)
		mon_reg == MCS_MON_RUN && !ref_rise && cnt_reg >= tmo_cyc
		&& sel_reg == sel_next |=> !ref_ok && mon_reg == MCS_MON_WAIT)
		else $error("Reference loss not flagged on timeout.");
	ctrl_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		acc_w && ctrl_hit |=> ctrl_reg == $past(pwdata[3:0]))
		else $error("Control register write lost.");
	unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && paddr != `MCS_CTRL_OFF && paddr != `MCS_STAT_OFF |-> pslverr)
		else $error("Unmapped access did not raise an error.");

	host_ok_c: cover property (@(posedge pclk) disable iff (!presetn) host_mode && $rose(ref_ok));
	t1_rate_c: cover property (@(posedge pclk) disable iff (!presetn)
		sel_reg.rate_t1 ##1 $rose(master_clk));
	loss_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(ref_ok));

endmodule // mcs_master_clk

/* File: mcs_params.svh */
// Offsets, field positions, reset values and rate constants of the master clock selector.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// Register byte offsets on the APB.
`define MCS_CTRL_OFF      12'h000
`define MCS_STAT_OFF      12'h004

// Control register fields.
`define MCS_CTRL_SEL_LSB  0
`define MCS_CTRL_RATE_BIT 3
`define MCS_CTRL_RST      4'h0

// Status register fields.
`define MCS_STAT_OK_BIT   0
`define MCS_STAT_RATE_BIT 1
`define MCS_STAT_SEL_LSB  2
`define MCS_STAT_SRC_BIT  5
`define MCS_STAT_HOST_BIT 6

// Bus clock and output rates, in kHz.
`define MCS_CLK_KHZ       10000
`define MCS_E1_KHZ        2048
`define MCS_T1_KHZ        1544

// Reference rates selected by codes 010 to 111, in kHz.
`define MCS_REF8_KHZ      8
`define MCS_REF16_KHZ     16
`define MCS_REF56_KHZ     56
`define MCS_REF64_KHZ     64
`define MCS_REF128_KHZ    128
`define MCS_REF256_KHZ    256

// Select codes that take the full-rate references.
`define MCS_SEL_E1_FULL   3'h0
`define MCS_SEL_T1_FULL   3'h1

`endif

/* File: mcs_pkg.sv */
// Types shared by the master clock selector modules.
package mcs_pkg;

	// Effective selection: reference code and output rate.
	typedef struct packed {
		logic [2:0] ref_sel;
		logic       rate_t1;
	} mcs_sel_t;

	// Which reference input is watched.
	typedef enum logic {
		MCS_SRC_E1,
		MCS_SRC_T1
	} mcs_src_t;

	// Reference monitor states.
	typedef enum logic {
		MCS_MON_WAIT,
		MCS_MON_RUN
	} mcs_mon_t;

endpackage

/* File: mcs_nco.sv */
// Phase accumulator that turns a frequency word into a square master clock.
`timescale 1ns/10ps
module mcs_nco #(
	parameter int ACC_W = 32
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [ACC_W-1:0] incr,
	output logic                  clk_out
);

	logic [ACC_W-1:0] acc_reg; // Phase accumulator.

	// Refuse an accumulator too narrow to resolve the output rates.
	if (ACC_W < 16) begin : g_bad_width
		$error("mcs_nco: ACC_W must be at least 16.");
	end

	// The accumulator advances by the frequency word every cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= '0;
		end else begin
			acc_reg <= acc_reg + incr;
		end
	end

	// The top phase bit is the output clock, so it comes straight from a flop.
	assign clk_out = acc_reg[ACC_W-1];

endmodule // mcs_nco

/* File: mcs_ref_src.sv */
// Board reference clock sources that feed the two reference inputs.
`timescale 1ns/10ps
module mcs_ref_src (
	input  wire logic        pclk,
	input  wire logic [15:0] period,
	input  wire logic        both,
	output logic             e1_clk,
	output logic             t1_clk
);
	logic [15:0] cnt; // Position within one reference period, in pclk cycles.
	logic        tgl; // Wrong-rate pattern for an input that nobody should watch.
	initial tgl = 1'b0;
	// A free toggle, so an ignored input never sits at a value the simulator settled.
	always @(posedge pclk) begin
		tgl <= ~tgl;
	end
	// Counts pclk cycles; a zero period holds the source still.
	always_ff @(posedge pclk) begin
		if (period == 16'h0 || cnt >= period - 16'h1) begin
			cnt <= 16'h0;
		end else begin
			cnt <= cnt + 16'h1;
		end
	end
	// The source drives the E1-rate input as a square wave.
	always_ff @(posedge pclk) begin
		e1_clk <= (period != 16'h0) && (cnt < (period >> 1));
	end
	// One source wired to both inputs; otherwise the T1-rate input carries the toggle.
	always_ff @(posedge pclk) begin
		t1_clk <= both ? ((period != 16'h0) && (cnt < (period >> 1))) : tgl;
	end
endmodule // mcs_ref_src

/* File: tb_top.sv */
// Self-checking testbench of the master clock selector.
`timescale 1ns/10ps
`include "mcs_params.svh"
module tb_top;
	import mcs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        host_mode, rate_pin, e1_in, t1_in, master_clk, master_rate_t1, ref_ok, er;
	logic [2:0]  sel_pin;
	logic [3:0]  tx_clk, rx_clk;
	logic [15:0] period;
	logic        both;
	int          err_count, num_checks, cyc;
	// Clock at 10 MHz; all inputs start settled.
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		host_mode = 0; sel_pin = 0; rate_pin = 0; period = 0; both = 0;
		err_count = 0; num_checks = 0; cyc = 0;
	end
	always #50 pclk = ~pclk;
	mcs_master_clk mcs_master_clk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .host_mode(host_mode), .ref_freq_select(sel_pin),
		.output_rate_select(rate_pin), .e1_rate_ref_clock_in(e1_in),
		.t1_rate_ref_clock_in(t1_in), .master_clk(master_clk), .tx_shaper_clk(tx_clk),
		.rx_recovery_clk(rx_clk), .master_rate_t1(master_rate_t1), .ref_ok(ref_ok));
	mcs_ref_src mcs_ref_src_inst (.pclk(pclk), .period(period), .both(both), .e1_clk(e1_in),
		.t1_clk(t1_in));
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			complete_run();
		end
	end
	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// One APB transfer; waits for pready and takes data and error at that edge.
	// Only the run's timeout ends the wait; the slave should answer at once.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		chk(n, 1, "access wait states");
		psel <= 0; penable <= 0;
	endtask
	// Waits, bounded, for the monitor to accept the reference.
	task automatic wait_ok(input int lim);
		for (int i = 0; i < lim && ref_ok !== 1'b1; i++) @(posedge pclk);
	endtask
	// Counts master clock edges over 2000 cycles and checks every channel copy.
	task automatic freq(input int khz);
		int n, bad;
		logic prev;
		n = 0; bad = 0; prev = master_clk;
		repeat (2000) begin
			@(posedge pclk);
			if (master_clk && !prev) n++;
			if (tx_clk !== {4{master_clk}} || rx_clk !== {4{master_clk}}) bad++;
			prev = master_clk;
		end
		chk(n >= khz / 5 - 2 && n <= khz / 5 + 2, 1, "master clock rate");
		chk(bad, 0, "channel clock copies");
	endtask
	// Reset values on the ports and in the registers, and an unmapped address.
	task automatic t_reset();
		repeat (10) @(posedge pclk);
		chk({master_clk, master_rate_t1, ref_ok, pready}, 4'h1, "outputs in reset");
		chk({tx_clk, rx_clk}, 8'h0, "channel clocks in reset");
		presetn <= 1;
		apb(`MCS_CTRL_OFF, 0, 0);
		chk(rd, 0, "control reset");
		apb(`MCS_STAT_OFF, 0, 0);
		chk(rd, 0, "status reset");
		apb(12'h008, 0, 0);
		chk(er, 1, "unmapped read error");
		chk(rd, 0, "unmapped read data");
		$display("Test done: reset");
	endtask
	// Every select code at both rates from the pins, reference on the proper input.
	task automatic t_table();
		int p;
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 2; r++) begin
				p = c == 0 ? 10000 / `MCS_E1_KHZ : c == 1 ? 10000 / `MCS_T1_KHZ :
					c == 2 ? 1250 : c == 3 ? 625 : c == 4 ? 178 : c == 5 ? 156 : c == 6 ? 78 : 39;
				@(posedge pclk);
				sel_pin <= c[2:0]; rate_pin <= r[0]; period <= p[15:0]; both <= c < 2;
				repeat (4) @(posedge pclk);
				wait_ok(4 * p + 50);
				chk(ref_ok, 1, "reference accepted");
				chk(master_rate_t1, r, "rate in force");
				apb(`MCS_STAT_OFF, 0, 0);
				chk(rd[6:1], {1'b0, c == 1, c[2:0], r[0]}, "status fields");
				freq(r ? `MCS_T1_KHZ : `MCS_E1_KHZ);
			end
		end
		$display("Test done: table");
	endtask
	// Code 001 watches the T1-rate input only; a wrong rate there is not accepted.
	task automatic t_t1_watch();
		@(posedge pclk);
		sel_pin <= `MCS_SEL_T1_FULL; period <= 16'd6; both <= 0;
		repeat (80) @(posedge pclk);
		chk(ref_ok, 0, "wrong T1-rate input");
		$display("Test done: t1 watch");
	endtask
	// Host mode takes the selection from the control register, then the reference stops.
	task automatic t_host();
		@(posedge pclk);
		host_mode <= 1; sel_pin <= 3'h2; rate_pin <= 0; period <= 16'd156; both <= 0;
		apb(`MCS_CTRL_OFF, 1, 32'hffff_fffd);
		apb(`MCS_CTRL_OFF, 0, 0);
		chk(rd, 32'hd, "control readback");
		repeat (4) @(posedge pclk);
		wait_ok(700);
		chk({ref_ok, master_rate_t1}, 2'h3, "host selection");
		apb(`MCS_STAT_OFF, 1, 0);
		chk(er, 0, "status write error");
		apb(`MCS_STAT_OFF, 0, 0);
		chk(rd, 32'h57, "status in host mode");
		freq(`MCS_T1_KHZ);
		apb(12'hffc, 1, 32'h5);
		chk(er, 1, "unmapped write");
		@(posedge pclk);
		period <= 0;
		repeat (330) @(posedge pclk);
		chk(ref_ok, 0, "reference lost");
		$display("Test done: host");
	endtask
	// Main sequence.
	initial begin
		t_reset();
		t_table();
		t_t1_watch();
		t_host();
		complete_run();
	end
endmodule // tb_top
